/* File: verilog/tsi_pkg.sv */
/*
  Shared constants and types of the time slot interchange switch pin logic.
  Assumes one system clock of 250 MHz and a synchronous active-high reset.
*/
package tsi_pkg;
  // Stream geometry
  localparam int TSI_NSTREAM = 8; // Serial streams in each direction
  localparam int TSI_NCHAN = 32; // Channels in one frame
  localparam int TSI_CHAN_W = 5; // Channel index width
  localparam int TSI_MEM_AW = 8; // Stream and channel address width
  localparam int TSI_FRAME_CNT_W = 9; // Serial clock cycles in a frame as bits
  localparam logic [8:0] TSI_FRAME_LAST = 9'h1ff; // Last serial clock cycle of a frame
  localparam int TSI_SER_CYC_PER_BIT = 2; // Serial clock cycles per stream bit
  localparam int TSI_DELAY_W = 4; // Width of a per-stream input delay, in bits
  // Frame pulse format detection
  localparam logic [4:0] TSI_IDLE_RUN = 5'h10; // Serial cycles at one level that mark idle
  // Timing against the 4 ns system clock
  localparam int TSI_SYS_PERIOD_NS = 4; // System clock period
  localparam int TSI_RESET_MIN_NS = 100; // Least reset pulse the host must give
  localparam int TSI_RESET_MIN_CYC =
    (TSI_RESET_MIN_NS + TSI_SYS_PERIOD_NS - 1) / TSI_SYS_PERIOD_NS; // Rounded up
  // Transmit prefetch pipeline
  localparam logic [3:0] TSI_FETCH_LAST = 4'ha; // Final step of a slot prefetch
  localparam logic [3:0] TSI_FETCH_START_PHASE = 4'h1; // Cycle in a slot that starts it
  // Host write commands, carried in data bits 9:8
  localparam logic [1:0] TSI_CMD_CONN = 2'h0; // Write a connection entry
  localparam logic [1:0] TSI_CMD_DELAY = 2'h1; // Write a stream input delay
  // Host port handshake states
  typedef enum logic [1:0] {TSI_H_IDLE, TSI_H_DATA, TSI_H_ACK, TSI_H_HIGH} tsi_host_e;
endpackage : tsi_pkg

/* File: verilog/tsi_ram.sv */
/*
  Simple dual-port memory: one write port, one read port with registered data.
  Assumes both ports are used in the system clock domain only.
*/
`timescale 1ns/1ps
module tsi_ram import tsi_pkg::*; #(
  parameter int AW = TSI_MEM_AW,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  // Refuse shapes the storage cannot take
  if (AW < 1 || AW > 12 || DW < 1) begin : g_bad
    $error("tsi_ram: unsupported width or depth");
  end

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem; // Storage words
    logic [DW-1:0] rd; // Registered read word
  } tsi_ram_s;

  tsi_ram_s st_q;
  tsi_ram_s st_d;

  // Next state: read first, read sees the old word on a collision
  always_comb begin
    st_d = st_q;
    st_d.rd = st_q.mem[rd_addr];
    if (wr_en) begin
      st_d.mem[wr_addr] = wr_data;
    end
  end

  // Reset clears the whole array so stale switching data never leaks out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd;
endmodule : tsi_ram

/* File: verilog/tsi_switch.sv */
/*
  Pin logic of a 256 by 256 channel time slot interchange switch: eight serial
  receive streams, eight three-state transmit streams, frame pulse format
  detection and a host port in three bus styles.
  Assumes every input is synchronous to sys_clk; the 4.096 MHz serial clock
  arrives as an ordinary input and is edge-detected here.
*/
// How it works
// - Any of 256 inputs reaches any output
// - Eight three-state transmit streams at stream rate
// - Eight receive streams sampled at stream rate
// - Detect frame pulse polarity, adapt stream timing
// - One serial clock shifts both directions
// - Reset clears counters and registers
// - Reset floats transmit and host data pins
// - Non-multiplexed style takes dedicated address lines
// - Multiplexed strobe style: strobe high, chip select
// - Non-multiplexed style: strobe low, chip select
// - Separate strobes: read strobe low drives bus
// - Strobe styles: direction input sets bus direction
// - Separate strobes: write strobe low accepts data
// - Programmable input delay per receive stream
// - Style pin high multiplexed, low non-multiplexed
// - Frames of 32 channels from frame pulse
// - Acknowledge low, then high, then released
`timescale 1ns/1ps
module tsi_switch import tsi_pkg::*; #(
  parameter int DELAY_W = TSI_DELAY_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ser_clk_in,
  input wire logic frame_pulse_in,
  input wire logic [7:0] serial_in_streams,
  output logic [7:0] serial_out_streams,
  output logic [7:0] serial_out_streams_en,
  input wire logic host_bus_style_sel,
  input wire logic sep_strobe_mode,
  input wire logic chip_sel_n,
  input wire logic addr_strobe,
  input wire logic data_strobe,
  input wire logic rd_wr,
  input wire logic [7:0] host_addr_lines,
  input wire logic [7:0] muxed_addr_data_low,
  output logic [7:0] muxed_addr_data_low_val,
  output logic [7:0] muxed_addr_data_low_en,
  input wire logic [7:0] upper_data_lines,
  output logic [7:0] upper_data_lines_val,
  output logic [7:0] upper_data_lines_en,
  output logic transfer_ack_n,
  output logic transfer_ack_n_en,
  output logic frame_format_gci,
  output logic frame_locked
);
  // Delay is counted in bits inside one 256-bit frame
  if (DELAY_W < 1 || DELAY_W > 8) begin : g_bad
    $error("tsi_switch: DELAY_W must lie in 1..8");
  end

  typedef struct packed {
    logic ser_last; // Serial clock level one system cycle ago
    logic [8:0] cnt; // Serial clock cycle within the frame
    logic fp_last; // Frame pulse level at the previous serial edge
    logic idle_lvl; // Resting level of the frame pulse
    logic [4:0] run; // Serial edges at an unchanged pulse level
    logic locked; // Pulse format has been identified
    logic [7:0][7:0] rx_sh; // Receive shifters
    logic [7:0] pend_v; // Received byte waits for memory
    logic [7:0][7:0] pend_b; // Waiting byte per stream
    logic [7:0][4:0] pend_ch; // Channel of the waiting byte
    logic [7:0][DELAY_W-1:0] dly; // Input delay per stream, in bits
    logic [7:0][7:0] tx_sh; // Transmit shifters
    logic [7:0][7:0] tx_nx; // Prefetched bytes for the next slot
    logic [3:0] fcnt; // Prefetch step, zero when idle
    tsi_host_e hst; // Host handshake state
    logic [15:0] dout; // Read data for the host
    logic [7:0] addr_lat; // Latched multiplexed address
  } tsi_state_s;

  tsi_state_s st_q;
  tsi_state_s st_d;

  // Lowest pending stream; stream 0 when the vector is empty
  function automatic logic [2:0] tsi_first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : tsi_first_set

  logic ser_rise; // Rising edge of the serial clock
  logic fstart; // Frame boundary seen on the pulse
  logic samp; // Receive sampling point
  logic fetch_go; // Start of a slot prefetch
  logic fbusy; // Prefetch owns the memory read ports
  logic muxed; // Multiplexed host bus style
  logic sep; // Separate read and write strobes
  logic access; // Host access in progress
  logic is_read; // Access direction
  logic take; // Host access accepted this cycle
  logic [7:0] haddr; // Host memory address
  logic [15:0] wdata; // Host write word
  logic [4:0] nxt_ch; // Channel being prefetched
  logic [2:0] wsel; // Stream whose byte is stored
  logic cm_we; // Connection entry write
  logic [7:0] cm_raddr; // Connection memory read address
  logic [7:0] cm_rd; // Connection entry: source stream and channel
  logic [7:0] dm_raddr; // Data memory read address
  logic [7:0] dm_rd; // Received byte

  // Serial clock edge and frame alignment
  assign ser_rise = ser_clk_in & ~st_q.ser_last;
  assign fstart = ser_rise & st_q.locked & (frame_pulse_in != st_q.idle_lvl)
    & (st_q.fp_last == st_q.idle_lvl);
  // Active-high pulses sample on even cycles, the other format on odd ones
  assign samp = ser_rise & (st_q.cnt[0] == ~frame_format_gci);
  assign fetch_go = ser_rise & (st_q.cnt[3:0] == TSI_FETCH_START_PHASE);
  assign fbusy = (st_q.fcnt != 4'h0);
  assign nxt_ch = st_q.cnt[8:4] + 5'h1;

  // Host bus style decode
  assign muxed = host_bus_style_sel;
  assign sep = muxed & sep_strobe_mode;
  always_comb begin
    if (sep) begin
      access = ~chip_sel_n & (~data_strobe | ~rd_wr);
      is_read = ~data_strobe;
    end else if (muxed) begin
      access = ~chip_sel_n & data_strobe;
      is_read = rd_wr;
    end else begin
      access = ~chip_sel_n & ~data_strobe;
      is_read = rd_wr;
    end
  end
  assign haddr = muxed ? st_q.addr_lat : host_addr_lines;
  assign wdata = {upper_data_lines, muxed_addr_data_low};
  // Prefetch has priority so a slot is never missed
  assign take = (st_q.hst == TSI_H_IDLE) & access & ~fbusy & ~fetch_go;
  assign cm_we = take & ~is_read & (wdata[9:8] == TSI_CMD_CONN);
  assign wsel = tsi_first_set(st_q.pend_v);

  // Memory read port steering between prefetch and host
  assign cm_raddr = (st_q.fcnt >= 4'h1 && st_q.fcnt <= 4'h8)
    ? {3'(st_q.fcnt - 4'h1), nxt_ch} : haddr;
  assign dm_raddr = (st_q.fcnt >= 4'h2 && st_q.fcnt <= 4'h9) ? cm_rd : haddr;

  // Received bytes stored at stream and channel
  tsi_ram #(.AW(TSI_MEM_AW), .DW(8)) u_data_mem (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(|st_q.pend_v),
    .wr_addr({wsel, st_q.pend_ch[wsel]}),
    .wr_data(st_q.pend_b[wsel]),
    .rd_addr(dm_raddr),
    .rd_data(dm_rd)
  );

  // Source address per output stream and channel
  tsi_ram #(.AW(TSI_MEM_AW), .DW(8)) u_conn_mem (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(cm_we),
    .wr_addr(haddr),
    .wr_data(wdata[7:0]),
    .rd_addr(cm_raddr),
    .rd_data(cm_rd)
  );

  // Next state of everything
  always_comb begin
    logic [7:0] pos;
    pos = 8'h0;
    st_d = st_q;
    st_d.ser_last = ser_clk_in;
    // Frame counter wraps every 512 serial cycles unless a pulse realigns it
    if (fstart) begin
      st_d.cnt = '0;
    end else if (ser_rise) begin
      st_d.cnt = st_q.cnt + 9'h1;
    end
    // The level that lasts is the idle level; its opposite is the pulse
    if (ser_rise) begin
      st_d.fp_last = frame_pulse_in;
      if (frame_pulse_in != st_q.fp_last) begin
        st_d.run = 5'h0;
      end else if (st_q.run != TSI_IDLE_RUN) begin
        st_d.run = st_q.run + 5'h1;
      end else begin
        st_d.idle_lvl = frame_pulse_in;
        st_d.locked = 1'b1;
      end
    end
    // Store one waiting byte per cycle; a new byte below wins over this clear
    if (|st_q.pend_v) begin
      st_d.pend_v[wsel] = 1'b0;
    end
    // Receive shifting with each stream offset by its own delay
    for (int s = 0; s < TSI_NSTREAM; s++) begin
      pos = st_q.cnt[8:1] - 8'(st_q.dly[s]);
      if (samp) begin
        st_d.rx_sh[s] = {st_q.rx_sh[s][6:0], serial_in_streams[s]};
        if (pos[2:0] == 3'h7) begin
          st_d.pend_v[s] = 1'b1;
          st_d.pend_b[s] = {st_q.rx_sh[s][6:0], serial_in_streams[s]};
          st_d.pend_ch[s] = pos[7:3];
        end
      end
      // Transmit: load at slot start, shift at each later bit start
      if (ser_rise && !st_q.cnt[0]) begin
        if (st_q.cnt[3:0] == 4'h0) begin
          st_d.tx_sh[s] = st_q.tx_nx[s];
        end else begin
          st_d.tx_sh[s] = {st_q.tx_sh[s][6:0], 1'b0};
        end
      end
    end
    // Prefetch one slot ahead: connection entry, then source byte
    if (fetch_go) begin
      st_d.fcnt = 4'h1;
    end else if (fbusy) begin
      st_d.fcnt = (st_q.fcnt == TSI_FETCH_LAST) ? 4'h0 : st_q.fcnt + 4'h1;
    end
    if (st_q.fcnt >= 4'h3) begin
      st_d.tx_nx[3'(st_q.fcnt - 4'h3)] = dm_rd;
    end
    // Address latch for the multiplexed styles
    if (muxed && addr_strobe) begin
      st_d.addr_lat = muxed_addr_data_low;
    end
    // Host handshake
    unique case (st_q.hst)
      TSI_H_IDLE: begin
        if (take) begin
          st_d.hst = is_read ? TSI_H_DATA : TSI_H_ACK;
          if (!is_read && wdata[9:8] == TSI_CMD_DELAY) begin
            st_d.dly[haddr[2:0]] = wdata[DELAY_W-1:0];
          end
        end
      end
      TSI_H_DATA: begin
        st_d.dout = {dm_rd, cm_rd};
        st_d.hst = TSI_H_ACK;
      end
      TSI_H_ACK: begin
        if (!access) begin
          st_d.hst = TSI_H_HIGH;
        end
      end
      TSI_H_HIGH: begin
        st_d.hst = TSI_H_IDLE;
      end
    endcase
  end

  // Reset clears every counter, shifter and handshake flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Pin drive; enables drop within the reset cycle itself
  always_comb begin
    for (int s = 0; s < TSI_NSTREAM; s++) begin
      serial_out_streams[s] = st_q.tx_sh[s][7];
    end
    serial_out_streams_en = {8{~srst & st_q.locked}};
    muxed_addr_data_low_en = {8{~srst & access & is_read}};
    upper_data_lines_en = {8{~srst & access & is_read}};
  end
  assign muxed_addr_data_low_val = st_q.dout[7:0];
  assign upper_data_lines_val = st_q.dout[15:8];
  assign transfer_ack_n = (st_q.hst != TSI_H_ACK);
  assign transfer_ack_n_en = ~srst & ((st_q.hst == TSI_H_ACK) | (st_q.hst == TSI_H_HIGH));
  assign frame_format_gci = st_q.locked & ~st_q.idle_lvl;
  assign frame_locked = st_q.locked;

  // Checks beside the logic
  AST_TX_FLOAT_RST: assert property (@(posedge sys_clk)
    srst |-> (serial_out_streams_en == 8'h0 && muxed_addr_data_low_en == 8'h0))
    else $error("transmit or data pins driven in reset");
  AST_CLEAR_RST: assert property (@(posedge sys_clk)
    srst |=> (st_q.cnt == 9'h0 && st_q.fcnt == 4'h0 && !frame_locked))
    else $error("counters not cleared by reset");
  AST_FRAME_WRAP: assert property (@(posedge sys_clk) disable iff (srst)
    (ser_rise && (fstart || st_q.cnt == TSI_FRAME_LAST)) |=> st_q.cnt == 9'h0)
    else $error("frame of 32 channels did not wrap");
  AST_BIT_TWO_CLK: assert property (@(posedge sys_clk) disable iff (srst)
    (ser_rise && st_q.cnt[0]) |=> $stable(serial_out_streams))
    else $error("transmit bit changed mid period");
  AST_PREFETCH_LEN: assert property (@(posedge sys_clk) disable iff (srst)
    fetch_go |=> (fbusy [*8]) ##1 fbusy ##1 fbusy ##1 !fbusy)
    else $error("slot prefetch length wrong");
  AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (srst)
    (transfer_ack_n_en && !transfer_ack_n && !access)
      |=> (transfer_ack_n_en && transfer_ack_n) ##1 !transfer_ack_n_en)
    else $error("acknowledge not driven high then released");
  AST_NONMUX_ADDR: assert property (@(posedge sys_clk) disable iff (srst)
    (cm_we && !host_bus_style_sel) |-> haddr == host_addr_lines)
    else $error("non-multiplexed write used wrong address");
  AST_SEP_READ_DRIVE: assert property (@(posedge sys_clk) disable iff (srst)
    (sep && !chip_sel_n && !data_strobe) |-> upper_data_lines_en == 8'hff)
    else $error("read strobe did not drive the data bus");
  AST_SEP_WRITE_IN: assert property (@(posedge sys_clk) disable iff (srst)
    (sep && data_strobe && !rd_wr) |-> muxed_addr_data_low_en == 8'h0)
    else $error("write strobe left the data bus driven");
  AST_STROBE_DIR: assert property (@(posedge sys_clk) disable iff (srst)
    (!sep && access && !rd_wr) |-> muxed_addr_data_low_en == 8'h0)
    else $error("write direction drove the data bus");
endmodule : tsi_switch

/* File: tb/tsi_far_model.sv */
/*
  Far side of the serial backplane: serial clock, frame pulse, receive data.
  Assumes sys_clk at 250 MHz; counts ones seen on transmit stream 0 a frame.
*/
`timescale 1ns/1ps
module tsi_far_model (
  input wire logic sys_clk,
  input wire logic [7:0] serial_out_streams,
  input wire logic pulse_active_high,
  output logic ser_clk_in,
  output logic frame_pulse_in,
  output logic [7:0] serial_in_streams,
  output logic [9:0] tx_ones,
  output logic [3:0] frames
);
  logic [5:0] div_q = 6'h00; // Sys cycles in a serial cycle
  logic [8:0] fcnt_q = 9'h1e2; // Starts late so the first pulse comes soon
  logic [9:0] ones_q = 10'h000; // Ones counted so far this frame
  initial begin
    ser_clk_in = 1'b0;
    frame_pulse_in = 1'b1;
    serial_in_streams = 8'haa; // Odd streams all ones, even all zeros
    tx_ones = 10'h3ff;
    frames = 4'h0;
  end
  // 61 sys cycles make one 4.096 MHz serial cycle
  always @(posedge sys_clk) begin
    div_q <= (div_q == 6'h3c) ? 6'h00 : div_q + 6'h01;
    ser_clk_in <= #1 (div_q >= 6'h1e);
    // Pulse one serial cycle in 512; polarity picks the format
    if (div_q == 6'h0f) begin
      fcnt_q <= fcnt_q + 9'h001;
      frame_pulse_in <= #1 (fcnt_q != 9'h1ff) ^ pulse_active_high;
    end
    // Sample half a serial cycle after the rise, where the output is settled
    if (div_q == 6'h00) begin
      if (fcnt_q == 9'h1ff) begin
        tx_ones <= ones_q + {9'h000, serial_out_streams[0]};
        ones_q <= 10'h000;
        frames <= frames + 4'h1;
      end else begin
        ones_q <= ones_q + {9'h000, serial_out_streams[0]};
      end
    end
  end
endmodule : tsi_far_model

/* File: tb/tsi_switch_tb.sv */
/*
  Self-checking bench of the switch: host port in all three styles, reset,
  frame lock and end-to-end switching through the far side model.
  Assumes the host bus pins resolve here from the design's enables.
*/
`timescale 1ns/1ps
module tsi_switch_tb import tsi_pkg::*;;
  logic sys_clk, srst, style, sep, cs_n, as, ds, rw;
  logic [7:0] addr, ad_tb, up_tb, ad_in, up_in, ad_val, ad_en, up_val, up_en;
  logic [7:0] rx, tx_val, tx_en;
  logic sclk, fp, ack, ack_en, gci, locked;
  logic fp_hi; // Far side sends an active-high frame pulse
  logic [9:0] tx_ones;
  logic [3:0] frames;
  int n_fail = 0;
  int n_tests = 0;
  // Wire level: design value where it drives, bench value elsewhere
  assign ad_in = (ad_en & ad_val) | (~ad_en & ad_tb);
  assign up_in = (up_en & up_val) | (~up_en & up_tb);
  tsi_switch dut (.sys_clk(sys_clk), .srst(srst), .ser_clk_in(sclk),
    .frame_pulse_in(fp), .serial_in_streams(rx), .serial_out_streams(tx_val),
    .serial_out_streams_en(tx_en), .host_bus_style_sel(style),
    .sep_strobe_mode(sep), .chip_sel_n(cs_n), .addr_strobe(as),
    .data_strobe(ds), .rd_wr(rw), .host_addr_lines(addr),
    .muxed_addr_data_low(ad_in), .muxed_addr_data_low_val(ad_val),
    .muxed_addr_data_low_en(ad_en), .upper_data_lines(up_in),
    .upper_data_lines_val(up_val), .upper_data_lines_en(up_en),
    .transfer_ack_n(ack), .transfer_ack_n_en(ack_en),
    .frame_format_gci(gci), .frame_locked(locked));
  tsi_far_model far (.sys_clk(sys_clk), .serial_out_streams(tx_val),
    .pulse_active_high(fp_hi),
    .ser_clk_in(sclk), .frame_pulse_in(fp), .serial_in_streams(rx),
    .tx_ones(tx_ones), .frames(frames));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // One host access; md 0 non-mux, 1 mux, 2 separate strobes
  task automatic xfer(input logic [1:0] md, input logic rd, input logic [7:0] a,
                      input logic [15:0] wd, output logic [15:0] rdat);
    int n;
    n = 0;
    style = (md != 2'h0);
    sep = (md == 2'h2);
    ds = (md != 2'h1); // Idle strobe level differs per style
    rw = 1'b1;
    tick();
    cs_n = 1'b0;
    if (md != 2'h0) begin // Address phase on the shared low byte
      as = 1'b1;
      ad_tb = a;
      tick();
      as = 1'b0;
    end
    addr = a;
    ad_tb = rd ? ~wd[7:0] : wd[7:0]; // Inverse while released, never stale
    up_tb = rd ? ~wd[15:8] : wd[15:8];
    ds = (md == 2'h2) ? ~rd : (md == 2'h1);
    rw = rd;
    do begin
      tick();
      n++;
    end while (!(ack_en === 1'b1 && ack === 1'b0) && n < 40);
    chk("ack_low", {14'h0, ack_en, ack}, 16'h0002);
    chk("bus_en", {up_en, ad_en}, rd ? 16'hffff : 16'h0000);
    rdat = {up_val, ad_val};
    cs_n = 1'b1;
    ds = (md != 2'h1);
    rw = 1'b1;
    tick();
    chk("ack_high", {14'h0, ack_en, ack}, 16'h0003);
    tick();
    chk("ack_off", {14'h0, ack_en, 1'b0}, 16'h0000);
    chk("bus_off", {up_en, ad_en}, 16'h0000);
  endtask : xfer
  // Reset pulse; outputs float and state clears
  task automatic t_reset(input int cyc);
    srst = 1'b1;
    repeat (cyc) tick();
    chk("tx_rst", {tx_en, tx_val}, 16'h0000);
    chk("bus_rst", {up_en, ad_en}, 16'h0000);
    chk("flags_rst", {13'h0, ack_en, locked, gci}, 16'h0000);
    srst = 1'b0;
    tick();
    $display("test reset done");
  endtask : t_reset
  // Writes and reads crossing all three bus styles, plus other commands
  task automatic t_styles;
    logic [15:0] r;
    xfer(2'h0, 1'b0, 8'h05, 16'h0022, r);
    xfer(2'h1, 1'b0, 8'h07, 16'h005c, r);
    xfer(2'h2, 1'b0, 8'h0b, 16'h0041, r);
    xfer(2'h0, 1'b0, 8'h0b, 16'h0177, r);
    xfer(2'h1, 1'b0, 8'h0b, 16'h02ff, r);
    xfer(2'h2, 1'b0, 8'h0b, 16'h03ff, r);
    xfer(2'h1, 1'b1, 8'h05, 16'h0000, r);
    chk("mux_rd", r, 16'h0022);
    xfer(2'h2, 1'b1, 8'h07, 16'h0000, r);
    chk("sep_rd", r, 16'h005c);
    xfer(2'h0, 1'b1, 8'h0b, 16'h0000, r);
    chk("nmx_rd", r, 16'h0041);
    $display("test styles done");
  endtask : t_styles
  // Strobe of wrong polarity, or no chip select, gets no answer
  task automatic t_refuse;
    logic seen;
    seen = 1'b0;
    style = 1'b1;
    sep = 1'b0;
    ds = 1'b0;
    cs_n = 1'b0;
    repeat (8) begin
      tick();
      seen = seen | ack_en;
    end
    cs_n = 1'b1;
    ds = 1'b1;
    repeat (8) begin
      tick();
      seen = seen | ack_en;
    end
    chk("refused", {15'h0, seen}, 16'h0000);
    ds = 1'b0;
    tick();
    $display("test refuse done");
  endtask : t_refuse
  // Lock, receive into memory and switch stream 1 ch 2 to stream 0 ch 5
  task automatic t_serial;
    logic [15:0] r;
    int n;
    n = 0;
    while (frames < 4'h3 && n < 80000) begin
      tick();
      n++;
    end
    chk("lock", {14'h0, locked, gci}, 16'h0002);
    chk("tx_en", {8'h0, tx_en}, 16'h00ff);
    chk("tx_ones", {6'h0, tx_ones}, 16'h0010);
    for (int s = 0; s < 8; s++) begin
      xfer(2'h0, 1'b1, {s[2:0], 5'h09}, 16'h0000, r);
      chk("dmem", r, {{8{s[0]}}, 8'h00});
    end
    $display("test serial done");
  endtask : t_serial
  // Active-high pulse after a reset: relock and report the other format
  task automatic t_gci;
    fp_hi = 1'b1;
    t_reset(TSI_RESET_MIN_CYC);
    repeat (3050) tick();
    chk("gci_lock", {14'h0, locked, gci}, 16'h0003);
    chk("gci_tx_en", {8'h0, tx_en}, 16'h00ff);
    $display("test gci done");
  endtask : t_gci
  // Cut a hang short well beyond the expected run
  initial begin
    #(90000 * 4);
    n_fail++;
    $display("timeout");
    wrap_up();
  end
  initial begin
    fp_hi = 1'b0;
    style = 1'b0;
    sep = 1'b0;
    cs_n = 1'b1;
    as = 1'b0;
    ds = 1'b1;
    rw = 1'b1;
    addr = 8'h00;
    ad_tb = 8'h00;
    up_tb = 8'h00;
    t_reset(8);
    t_styles();
    t_refuse();
    t_serial();
    t_gci();
    wrap_up();
  end
endmodule : tsi_switch_tb
